/* hdl/kms_pkg.sv */
/*
 * Shared constants for the key matrix scanner: timing, result codes,
 * scan states and the seven-segment glyph table.
 * Assumes a 40 MHz sys_clk and a 4 x 4 matrix with pulled-up returns.
 */
package kms_pkg;
	//------------------------------------------------------------
	// timing
	//------------------------------------------------------------
	localparam int KMS_CLK_MHZ    = 40;
	localparam int KMS_SCAN_MS    = 30;
	localparam int KMS_SCAN_CYC   = KMS_SCAN_MS * KMS_CLK_MHZ * 1000;
	localparam int KMS_MUX_US     = 1000;
	localparam int KMS_MUX_CYC    = KMS_MUX_US * KMS_CLK_MHZ;
	localparam int KMS_PRE_NS     = 250;
	localparam int KMS_PRE_CYC    = (KMS_PRE_NS * KMS_CLK_MHZ + 999) / 1000;
	localparam int KMS_SETTLE_NS  = 5000;
	localparam int KMS_SETTLE_CYC = (KMS_SETTLE_NS * KMS_CLK_MHZ + 999) / 1000;
	localparam int KMS_WAIT_W     = 8;

	//------------------------------------------------------------
	// matrix and result codes
	//------------------------------------------------------------
	localparam int         KMS_LINES      = 4;
	localparam logic [4:0] KMS_CODE_BASE  = 5'h01;
	localparam logic [4:0] KMS_CODE_TEN   = 5'h0A;
	localparam logic [7:0] KMS_SHOW_NONE  = 8'h00;
	localparam logic [7:0] KMS_SHOW_MULTI = 8'hFF;
	localparam logic [7:0] KMS_NO_RESULT  = 8'hEE;

	typedef enum logic [2:0] {ST_IDLE, ST_PRE, ST_SETTLE, ST_SAMPLE, ST_JUDGE, ST_WAIT}
		kms_state_e;

	// segments active high, bit 7 is the decimal point (kept dark)
	localparam logic [7:0] KMS_SEG_TBL [0:15] = '{
		8'h3F, 8'h06, 8'h5B, 8'h4F, 8'h66, 8'h6D, 8'h7D, 8'h07,
		8'h7F, 8'h6F, 8'h77, 8'h7C, 8'h39, 8'h5E, 8'h79, 8'h71};
	localparam logic [1:0] KMS_DIG_LO = 2'h1;
	localparam logic [1:0] KMS_DIG_HI = 2'h2;
endpackage : kms_pkg

/* hdl/kms_disp_if.sv */
/*
 * Carries the two display nibbles from the scanner to the digit mux.
 * Assumes both ends run on sys_clk.
 */
`timescale 1ns/10ps
`default_nettype none
interface kms_disp_if;
	logic [3:0] hi_nib;
	logic [3:0] lo_nib;

	modport src (output hi_nib, output lo_nib);
	modport dst (input hi_nib, input lo_nib);
endinterface : kms_disp_if
`default_nettype wire

/* hdl/kms_tick_div.sv */
/*
 * Counter divider giving a one-cycle tick every COUNT cycles while run is high.
 * Assumes a single sys_clk domain; dropping run restarts the period.
 */
`timescale 1ns/10ps
`default_nettype none
module kms_tick_div
	import kms_pkg::*;
#(
	parameter int COUNT = 1000
)(
	input  wire logic sys_clk,
	input  wire logic reset_n,
	input  wire logic run,
	output var  logic tick
);
	localparam int W = $clog2(COUNT + 1);
	logic [W-1:0] cnt_r;
	wire          at_end = (cnt_r == W'(COUNT - 1));

	//------------------------------------------------------------
	// period counter
	//------------------------------------------------------------
	// cleared while stopped so every run starts a full period
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n || !run)
			cnt_r <= '0;
		else
			cnt_r <= at_end ? '0 : cnt_r + 1'b1;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			tick <= 1'b0;
		else
			tick <= run && at_end;
	end

	a_tick_spacing : assert property (@(posedge sys_clk) disable iff (!reset_n)
		tick |-> ##1 !tick)
		else $error("divider tick lasted more than one cycle");
endmodule : kms_tick_div
`default_nettype wire

/* hdl/kms_seg_mux.sv */
/*
 * Two-digit seven-segment multiplexer: alternates digit selects and
 * shared segment data on each mux tick.
 * Assumes digits and segments are active high at the pins.
 */
`timescale 1ns/10ps
`default_nettype none
module kms_seg_mux
	import kms_pkg::*;
(
	input  wire logic  sys_clk,
	input  wire logic  reset_n,
	input  wire logic  mux_tick,
	kms_disp_if.dst    disp,
	output var  logic [7:0] seg_data,
	output var  logic [1:0] digit_sel
);
	wire       show_hi = (digit_sel == KMS_DIG_LO);
	wire [3:0] nib     = show_hi ? disp.hi_nib : disp.lo_nib;

	//------------------------------------------------------------
	// digit alternation
	//------------------------------------------------------------
	// segments change together with the select, so no ghost of the other digit
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			digit_sel <= KMS_DIG_LO;
			seg_data  <= KMS_SEG_TBL[0];
		end
		else if (mux_tick)
		begin
			digit_sel <= show_hi ? KMS_DIG_HI : KMS_DIG_LO;
			seg_data  <= KMS_SEG_TBL[nib];
		end
	end

	a_digit_onehot : assert property (@(posedge sys_clk) disable iff (!reset_n)
		$onehot(digit_sel))
		else $error("digit selects not one-hot");

	a_mux_toggle : assert property (@(posedge sys_clk) disable iff (!reset_n)
		mux_tick |=> digit_sel != $past(digit_sel))
		else $error("digit did not alternate on mux tick");
endmodule : kms_seg_mux
`default_nettype wire

/* hdl/kms_scanner.sv */
/*
 * Key matrix scanner top: idle wait with all lines low, key press event,
 * timed scans with two-scan debounce, and two-digit display of the result.
 * Assumes return inputs are pulled up outside and synchronous to sys_clk;
 * a pad combines scan_out and scan_oe into the real pin.
 */
`timescale 1ns/10ps
`default_nettype none
module kms_scanner
	import kms_pkg::*;
#(
	parameter int SCAN_TICKS = KMS_SCAN_CYC,
	parameter int MUX_TICKS  = KMS_MUX_CYC
)(
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	input  wire logic [3:0] key_return_inputs,
	output var  logic [3:0] scan_out,
	output var  logic [3:0] scan_oe,
	output var  logic [7:0] seg_data,
	output var  logic [1:0] digit_sel,
	output var  logic       key_press_event,
	output var  logic       scan_tick_event
);
	//------------------------------------------------------------
	// state
	//------------------------------------------------------------
	kms_state_e              state_r, state_nxt;
	logic [2:0]              idx_r;
	logic [KMS_WAIT_W-1:0]   wait_r;
	logic [1:0]              hit_cnt_r;
	logic [4:0]              code_r;
	logic [7:0]              prev_r;
	logic [7:0]              shown_r;

	//------------------------------------------------------------
	// return decode
	//------------------------------------------------------------
	// returns read low for a pressed key because of the pull-ups
	wire [3:0] hits      = ~key_return_inputs;
	wire       press_any = |hits;
	wire [2:0] row_cnt   = 3'(hits[0]) + 3'(hits[1]) + 3'(hits[2]) + 3'(hits[3]);
	wire [1:0] row_first = hits[0] ? 2'd0 : hits[1] ? 2'd1 : hits[2] ? 2'd2 : 2'd3;
	wire [4:0] row_code  = {1'b0, idx_r[1:0], row_first} + KMS_CODE_BASE;
	wire [3:0] cnt_sum   = 4'(hit_cnt_r) + 4'(row_cnt);
	wire [1:0] cnt_nxt   = (cnt_sum >= 4'd2) ? 2'd2 : cnt_sum[1:0];

	// decimal digits for 01..16, or the fixed none/multi patterns
	wire       code_ten  = (code_r >= KMS_CODE_TEN);
	wire [4:0] code_unit = code_ten ? code_r - KMS_CODE_TEN : code_r;
	wire [7:0] code_bcd  = {3'h0, code_ten, code_unit[3:0]};
	wire [7:0] result    = (hit_cnt_r == 2'd0) ? KMS_SHOW_NONE :
	                       (hit_cnt_r == 2'd1) ? code_bcd      :
	                                             KMS_SHOW_MULTI;
	wire       agree     = (result == prev_r);
	wire       last_line = (idx_r == 3'(KMS_LINES - 1));
	wire       pre_done  = (wait_r == KMS_WAIT_W'(KMS_PRE_CYC - 1));
	wire       set_done  = (wait_r == KMS_WAIT_W'(KMS_SETTLE_CYC - 1));

	//------------------------------------------------------------
	// sequencer
	//------------------------------------------------------------
	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE:   if (press_any) state_nxt = ST_PRE;
			ST_PRE:    if (pre_done)
				state_nxt = (idx_r == 3'(KMS_LINES)) ? ST_JUDGE : ST_SETTLE;
			ST_SETTLE: if (set_done) state_nxt = ST_SAMPLE;
			ST_SAMPLE: state_nxt = ST_PRE;
			ST_JUDGE:  state_nxt = (agree && result == KMS_SHOW_NONE)
			                       ? ST_IDLE : ST_WAIT;
			ST_WAIT:   if (scan_tick_event) state_nxt = ST_PRE;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			state_r <= ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// phase timer for precharge and settle; cleared on every state change
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n || state_nxt != state_r)
			wait_r <= '0;
		else if (state_r == ST_PRE || state_r == ST_SETTLE)
			wait_r <= wait_r + 1'b1;
	end

	// line index: 0..3 are scan lines, 4 is the release-all precharge
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			idx_r <= '0;
		else if (state_r == ST_IDLE || state_r == ST_WAIT)
			idx_r <= '0;
		else if (state_r == ST_SAMPLE)
			idx_r <= idx_r + 1'b1;
	end

	// accumulate hits over one scan; cleared before each scan begins
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n || state_r == ST_IDLE || state_r == ST_WAIT)
		begin
			hit_cnt_r <= '0;
			code_r    <= '0;
		end
		else if (state_r == ST_SAMPLE && row_cnt != 3'd0)
		begin
			hit_cnt_r <= cnt_nxt;
			code_r    <= row_code;
		end
	end

	//------------------------------------------------------------
	// debounce and shown value
	//------------------------------------------------------------
	// prev starts at an impossible value so one bouncy scan never counts twice
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			prev_r  <= KMS_NO_RESULT;
			shown_r <= KMS_SHOW_NONE;
		end
		else if (state_r == ST_IDLE)
			prev_r <= KMS_NO_RESULT;
		else if (state_r == ST_JUDGE)
		begin
			prev_r <= result;
			if (agree)
				shown_r <= result;
		end
	end

	//------------------------------------------------------------
	// scan line drive
	//------------------------------------------------------------
	// low means active; released lines are floated, never left driven high
	wire [3:0] act_mask = (idx_r < 3'(KMS_LINES)) ? 4'(4'h1 << idx_r[1:0]) : 4'h0;
	wire [3:0] out_nxt  = (state_r == ST_PRE) ? ~act_mask : 4'h0;
	wire [3:0] oe_nxt   = (state_r == ST_IDLE || state_r == ST_PRE) ? 4'hF :
	                      (state_r == ST_SETTLE || state_r == ST_SAMPLE) ? act_mask :
	                      4'h0;

	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			scan_out <= 4'h0;
			scan_oe  <= 4'hF;
		end
		else
		begin
			scan_out <= out_nxt;
			scan_oe  <= oe_nxt;
		end
	end

	// one pulse per wake-up from idle
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			key_press_event <= 1'b0;
		else
			key_press_event <= (state_r == ST_IDLE) && press_any;
	end

	//------------------------------------------------------------
	// timers and display
	//------------------------------------------------------------
	// the interval timer only runs while scanning, so idle costs nothing
	kms_tick_div #(.COUNT(SCAN_TICKS)) interval_timer_unit (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.run     (state_r != ST_IDLE),
		.tick    (scan_tick_event)
	);

	logic mux_tick;
	kms_tick_div #(.COUNT(MUX_TICKS)) mux_timer (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.run     (1'b1),
		.tick    (mux_tick)
	);

	kms_disp_if disp ();
	assign disp.hi_nib = shown_r[7:4];
	assign disp.lo_nib = shown_r[3:0];

	kms_seg_mux seg_mux (
		.sys_clk   (sys_clk),
		.reset_n   (reset_n),
		.mux_tick  (mux_tick),
		.disp      (disp),
		.seg_data  (seg_data),
		.digit_sel (digit_sel)
	);

	//------------------------------------------------------------
	// checks
	//------------------------------------------------------------
	// independent tally of all hits in one scan, so the result checks below
	// do not merely restate the saturating counter that they guard
	logic [4:0] chk_sum_r;

	always_ff @(posedge sys_clk)
	begin
		if (!reset_n || state_r == ST_IDLE || state_r == ST_WAIT)
			chk_sum_r <= 5'h00;
		else if (state_r == ST_SAMPLE)
			chk_sum_r <= chk_sum_r + 5'(row_cnt);
	end

	sequence s_judge_agree;
		state_r == ST_JUDGE && agree;
	endsequence

	sequence s_judge_differ;
		state_r == ST_JUDGE && !agree;
	endsequence

	sequence s_scan_step;
		state_r == ST_SAMPLE && !last_line;
	endsequence

	sequence s_scan_last;
		state_r == ST_SAMPLE && last_line;
	endsequence

	// pins lag the state by one cycle, hence the $past on the state side
	a_idle_lines_low : assert property (@(posedge sys_clk) disable iff (!reset_n)
		$past(state_r) == ST_IDLE && $past(reset_n) |-> scan_oe == 4'hF && scan_out == 4'h0)
		else $error("idle lines not all driven low");

	a_press_event : assert property (@(posedge sys_clk) disable iff (!reset_n)
		state_r == ST_IDLE && press_any |=> key_press_event ##1 state_r != ST_IDLE)
		else $error("press in idle raised no event");

	a_event_pulse : assert property (@(posedge sys_clk) disable iff (!reset_n)
		key_press_event |=> !key_press_event)
		else $error("key press event lasted more than one cycle");

	a_one_line_scan : assert property (@(posedge sys_clk) disable iff (!reset_n)
		$past(state_r) == ST_SAMPLE |-> $onehot(scan_oe) && scan_out == 4'h0)
		else $error("sampling without exactly one low line");

	a_scan_next : assert property (@(posedge sys_clk) disable iff (!reset_n)
		s_scan_step |=> state_r == ST_PRE && idx_r == $past(idx_r) + 3'h1)
		else $error("scan did not move to the next line");

	a_judge_entry : assert property (@(posedge sys_clk) disable iff (!reset_n)
		state_r == ST_JUDGE |-> idx_r == 3'(KMS_LINES) && $past(state_r) == ST_PRE)
		else $error("judged before all lines were scanned");

	a_high_only_pre : assert property (@(posedge sys_clk) disable iff (!reset_n)
		(scan_oe & scan_out) != 4'h0 |-> $past(state_r) == ST_PRE)
		else $error("scan line driven high outside precharge");

	a_wait_floats : assert property (@(posedge sys_clk) disable iff (!reset_n)
		$past(state_r) == ST_WAIT |-> scan_oe == 4'h0)
		else $error("scan line driven between scans");

	a_pre_before_float : assert property (@(posedge sys_clk) disable iff (!reset_n)
		state_r == ST_PRE && $past(state_r) != ST_PRE |-> state_r == ST_PRE [*8])
		else $error("precharge shorter than its minimum");

	a_last_release : assert property (@(posedge sys_clk) disable iff (!reset_n)
		s_scan_last |=> state_r == ST_PRE && idx_r == 3'(KMS_LINES))
		else $error("last line not followed by the release-all precharge");

	a_wait_tick : assert property (@(posedge sys_clk) disable iff (!reset_n)
		state_r == ST_WAIT && scan_tick_event |=> state_r == ST_PRE)
		else $error("tick did not start a scan");

	a_accept_match : assert property (@(posedge sys_clk) disable iff (!reset_n)
		s_judge_agree |=> shown_r == $past(result))
		else $error("matching scans not accepted");

	// judged in the cycle right after, so a tick early in the wait cannot trip it
	a_keep_mismatch : assert property (@(posedge sys_clk) disable iff (!reset_n)
		s_judge_differ |=> $stable(shown_r) && state_r == ST_WAIT)
		else $error("mismatch changed the shown value");

	a_multi_ff : assert property (@(posedge sys_clk) disable iff (!reset_n)
		state_r == ST_JUDGE && chk_sum_r > 5'h01 |-> result == KMS_SHOW_MULTI)
		else $error("several keys not shown as FF");

	a_none_00 : assert property (@(posedge sys_clk) disable iff (!reset_n)
		state_r == ST_JUDGE && chk_sum_r == 5'h00 |-> result == KMS_SHOW_NONE)
		else $error("no key not shown as 00");

	a_code_range : assert property (@(posedge sys_clk) disable iff (!reset_n)
		state_r == ST_JUDGE && chk_sum_r == 5'h01
		|-> code_r >= KMS_CODE_BASE && code_r <= 5'h10)
		else $error("single key code out of range");

	a_release_idle : assert property (@(posedge sys_clk) disable iff (!reset_n)
		s_judge_agree ##0 result == KMS_SHOW_NONE |=> state_r == ST_IDLE ##1 scan_oe == 4'hF)
		else $error("release did not return to idle");
endmodule : kms_scanner
`default_nettype wire

/* bench/kms_matrix_model.sv */
/*
 * Behavioural 4 x 4 key switch matrix that sits on the scan and return lines.
 * Assumes each return line has a pull-up and a scan pin floats when its enable is low.
 */
`timescale 1ns/10ps
`default_nettype none
module kms_matrix_model
	import kms_pkg::*;
(
	input  wire logic [15:0] pressed,
	input  wire logic [3:0]  scan_out,
	input  wire logic [3:0]  scan_oe,
	output var  logic [3:0]  key_return_inputs
);
	//------------------------------------------------------------
	// wire levels
	//------------------------------------------------------------
	logic [3:0] line_lvl;

	// a released scan line is pulled high; driven high and released both read high
	assign line_lvl = scan_out | ~scan_oe;

	// a closed key ties its return to a low scan line; otherwise the pull-up wins
	always_comb
	begin
		key_return_inputs = 4'hF;
		for (int l = 0; l < 4; l++)
			for (int r = 0; r < 4; r++)
				if (pressed[l * 4 + r] && !line_lvl[l])
					key_return_inputs[r] = 1'b0;
	end
endmodule : kms_matrix_model
`default_nettype wire

/* bench/tb.sv */
/*
 * Self-checking bench for the key matrix scanner with a matrix model.
 * Assumes shortened scan and mux periods set through the top's parameters.
 */
`timescale 1ns/10ps
`default_nettype none
module tb
	import kms_pkg::*;
;
	localparam int SCAN_T = 1500;
	localparam int MUX_T  = 16;
	logic        sys_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [15:0] pressed = 16'h0000;
	wire  [3:0]  key_return_inputs;
	wire  [3:0]  scan_out;
	wire  [3:0]  scan_oe;
	wire  [7:0]  seg_data;
	wire  [1:0]  digit_sel;
	wire         key_press_event;
	wire         scan_tick_event;
	int          err_total = 0;
	int          total_checks = 0;
	int          bad_cnt = 0;
	int          tick_cnt = 0;
	int          keys [5];

	always #12.5 sys_clk = ~sys_clk;

	kms_scanner #(.SCAN_TICKS(SCAN_T), .MUX_TICKS(MUX_T)) dut_u (.sys_clk(sys_clk),
		.reset_n(reset_n), .key_return_inputs(key_return_inputs), .scan_out(scan_out),
		.scan_oe(scan_oe), .seg_data(seg_data), .digit_sel(digit_sel),
		.key_press_event(key_press_event), .scan_tick_event(scan_tick_event));
	kms_matrix_model mdl_u (.pressed(pressed), .scan_out(scan_out), .scan_oe(scan_oe),
		.key_return_inputs(key_return_inputs));

	// watch lines: outside idle and precharge never more than one line pulled low
	always @(posedge sys_clk)
	begin
		if (reset_n && $countones(scan_oe & ~scan_out) > 1 && scan_oe !== 4'hF)
			bad_cnt++;
		if (scan_tick_event === 1'b1)
			tick_cnt++;
	end

	//------------------------------------------------------------
	// shared tasks
	//------------------------------------------------------------
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run

	task automatic check(logic [15:0] seen, logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic cyc(int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : cyc

	// expected glyph pair, high digit first; 255 means several keys
	function automatic logic [15:0] glyphs(int c);
		if (c == 255)
			return {KMS_SEG_TBL[15], KMS_SEG_TBL[15]};
		return {KMS_SEG_TBL[c / 10], KMS_SEG_TBL[c % 10]};
	endfunction : glyphs

	// both digits are caught over two mux periods; a digit never shown stays unknown
	task automatic see_disp(output logic [15:0] g);
		g = 16'hxxxx;
		repeat (2 * MUX_T + 4)
		begin
			cyc(1);
			if (digit_sel === KMS_DIG_LO)
				g[7:0] = seg_data;
			if (digit_sel === KMS_DIG_HI)
				g[15:8] = seg_data;
		end
	endtask : see_disp

	task automatic wait_disp(logic [15:0] e);
		logic [15:0] g;
		for (int i = 0; i < 300; i++)
		begin
			see_disp(g);
			if (g === e)
				break;
		end
		check(g, e);
	endtask : wait_disp

	// press a key set, follow the scan, then release and watch the return to idle
	task automatic press_test(logic [15:0] mask, int code, bit timed);
		logic [15:0] g;
		int          n;
		int          t0;
		@(posedge sys_clk);
		pressed <= mask;
		n = 0;
		do
		begin
			cyc(1);
			n++;
		end
		while (key_press_event !== 1'b1 && n < 8);
		if (n >= 8)
		begin
			err_total++;
			complete_run();
		end
		cyc(1);
		check({scan_oe, scan_out}, 16'h00FE);
		cyc(10);
		check({scan_oe, scan_out}, 16'h0010);
		cyc(1080);
		see_disp(g);
		check(g, glyphs(0));
		wait_disp(glyphs(code));
		if (timed)
		begin
			n = 0;
			while (scan_tick_event !== 1'b1 && n < 2 * SCAN_T)
			begin
				cyc(1);
				n++;
			end
			n = 0;
			do
			begin
				cyc(1);
				n++;
			end
			while (scan_tick_event !== 1'b1 && n < 2 * SCAN_T);
			check(16'(n), 16'(SCAN_T));
		end
		@(posedge sys_clk);
		pressed <= 16'h0000;
		wait_disp(glyphs(0));
		t0 = tick_cnt;
		cyc(SCAN_T + 200);
		check(16'(tick_cnt - t0), 16'h0000);
		check({scan_oe, scan_out}, 16'h00F0);
		$display("test done keys %h", mask);
	endtask : press_test

	//------------------------------------------------------------
	// main sequence
	//------------------------------------------------------------
	initial
	begin
		logic [1:0] d;
		int         n;
		int         k;
		void'($urandom(41537));
		repeat (12) @(posedge sys_clk);
		reset_n <= 1'b1;
		cyc(1);
		check({scan_oe, scan_out, seg_data}, 16'hF03F);
		check(16'(digit_sel), 16'h0001);
		// digit alternation period
		for (int p = 0; p < 2; p++)
		begin
			d = digit_sel;
			n = 0;
			while (digit_sel === d && n < 64)
			begin
				cyc(1);
				n++;
			end
		end
		check(16'(n), 16'(MUX_T));
		check(16'(d ^ digit_sel), 16'h0003);
		$display("test done mux");
		keys = '{0, 9, 15, $urandom % 16, $urandom % 16};
		foreach (keys[i])
			press_test(16'h0001 << keys[i], keys[i] + 1, i == 0);
		k = $urandom % 16;
		press_test((16'h0001 << k) | (16'h0001 << ((k + 1 + $urandom % 15) % 16)), 255, 0);
		check(16'(bad_cnt), 16'h0000);
		complete_run();
	end
endmodule : tb
`default_nettype wire
